// ---- logic/vga_plane_path_control.sv ----
// module: vga emulation write/read path control registers and data paths
`timescale 1ns/1ps
`default_nettype none

module vga_plane_path_control (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  // register access
  input wire vga_plane_path_pkg::reg_req_type REG_REQ_IN,
  output logic REG_HIT_OUT,
  output logic REG_ACK_OUT,
  output logic [31:0] REG_RDATA_OUT,
  // sequencer byte requests
  input wire logic WR_REQ_IN,
  input wire logic [15:0] WR_ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic RD_REQ_IN,
  input wire logic [15:0] RD_ADDR_IN,
  output logic RD_VALID_OUT,
  output logic [7:0] RD_DATA_OUT,
  // plane memory
  output var vga_plane_path_pkg::mem_req_type MEM_REQ_OUT,
  input wire logic MEM_RDATA_VALID_IN,
  input wire logic [31:0] MEM_RDATA_IN
);
  import vga_plane_path_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // offset falls inside the decoded window
  function automatic logic in_window(input logic [15:0] a);
    in_window = (a >= REGION_START) && (a < REGION_END);
  endfunction : in_window

  // eight-bit right rotator
  function automatic logic [7:0] rot8(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] t;
    t = {d, d} >> n;
    rot8 = t[7:0];
  endfunction : rot8

  // vga address to longword address in graphics memory
  function automatic logic [19:0] map_addr(input logic [15:0] a, input logic [5:0] base,
                                           input logic [31:0] rctl);
    logic [15:0] v;
    v = a;
    if (rctl[RD_FORCE15_BIT]) begin
      v[15] = 1'b0;
    end
    if (rctl[RD_CHAIN4_BIT]) begin
      // packed mode folds four chained bytes into one longword
      v = rctl[RD_PACKED4_BIT] ? {2'b00, v[15:2]} : {v[15:2], 2'b00};
    end else if (rctl[RD_ODD_EVEN_BIT]) begin
      v[0] = rctl[RD_PAGE_BIT];
    end
    map_addr = {base, 14'h0000} + {4'h0, v};
  endfunction : map_addr

  // ****************************************
  // state
  // ****************************************
  logic [31:0] wr_ctrl_q, wr_ctrl_d; // vga_write_path_control
  logic [31:0] rd_ctrl_q, rd_ctrl_d; // vga_read_path_control
  logic [5:0] base_q, base_d; // vga_memory_base_offset
  logic [31:0] latch_q, latch_d; // vga_display_latch
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  mem_req_type mem_q, mem_d;
  logic [1:0] rd_plane_q, rd_plane_d; // plane picked at request time
  logic rd_valid_q, rd_valid_d;
  logic [7:0] rd_data_q, rd_data_d;

  // ****************************************
  // register file
  // ****************************************
  logic hit;
  assign hit = in_window(REG_REQ_IN.addr);
  assign REG_HIT_OUT = hit;

  // next values of the software registers
  always_comb begin
    wr_ctrl_d = wr_ctrl_q;
    rd_ctrl_d = rd_ctrl_q;
    base_d = base_q;
    latch_d = latch_q;
    ack_d = hit && (REG_REQ_IN.wr || REG_REQ_IN.rd);
    rdata_d = rdata_q;
    // a read return loads the latch; a software write in the same cycle wins
    if (MEM_RDATA_VALID_IN) begin
      latch_d = MEM_RDATA_IN;
    end
    if (hit && REG_REQ_IN.wr) begin
      unique case (REG_REQ_IN.addr)
        OFF_WRITE_CTRL: wr_ctrl_d = REG_REQ_IN.wdata & WRITE_CTRL_MASK;
        OFF_READ_CTRL: rd_ctrl_d = REG_REQ_IN.wdata & READ_CTRL_MASK;
        OFF_MEM_BASE: base_d = REG_REQ_IN.wdata[BASE_WR_LSB +: BASE_W];
        OFF_LATCH: latch_d = REG_REQ_IN.wdata;
        default: ; // unmapped offsets in the window take no write
      endcase
    end
    if (hit && REG_REQ_IN.rd) begin
      unique case (REG_REQ_IN.addr)
        OFF_WRITE_CTRL: rdata_d = wr_ctrl_q;
        OFF_READ_CTRL: rdata_d = rd_ctrl_q;
        // write-only field reads as zero, stored base shows higher up
        OFF_MEM_BASE: rdata_d = {18'h00000, base_q, 8'h00};
        OFF_LATCH: rdata_d = latch_q;
        default: rdata_d = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // register stage of the software registers
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      wr_ctrl_q <= WRITE_CTRL_RESET;
      rd_ctrl_q <= READ_CTRL_RESET;
      base_q <= BASE_RESET;
      latch_q <= LATCH_RESET;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_ctrl_q <= wr_ctrl_d;
      rd_ctrl_q <= rd_ctrl_d;
      base_q <= base_d;
      latch_q <= latch_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign REG_ACK_OUT = ack_q;
  assign REG_RDATA_OUT = rdata_q;

  // ****************************************
  // write path
  // ****************************************
  logic [7:0] rotated;
  logic [3:0] chain_en;
  logic [31:0] wr_word;
  logic [7:0] plane_d, plane_m;

  // byte to four-plane longword, read path steers chain 2 for writes
  always_comb begin
    rotated = rot8(WR_DATA_IN, wr_ctrl_q[WR_ROTATE_LSB +: 3]);
    if (rd_ctrl_q[RD_CHAIN4_BIT]) begin
      chain_en = 4'h1 << WR_ADDR_IN[1:0];
    end else if (rd_ctrl_q[RD_WR_CHAIN2_BIT]) begin
      chain_en = WR_ADDR_IN[0] ? 4'hA : 4'h5;
    end else begin
      chain_en = 4'hF;
    end
    wr_word = 32'h0000_0000;
    plane_d = 8'h00;
    plane_m = 8'h00;
    for (int p = 0; p < PLANES; p++) begin
      if (wr_ctrl_q[WR_MODE3_BIT]) begin
        // mode 3 wins when both mode bits are set
        plane_d = {8{wr_ctrl_q[WR_SET_RESET_VAL_LSB + p]}};
        plane_m = wr_ctrl_q[WR_BIT_MASK_LSB +: 8] & rotated;
      end else if (wr_ctrl_q[WR_MODE2_BIT]) begin
        plane_d = {8{WR_DATA_IN[p]}};
        plane_m = wr_ctrl_q[WR_BIT_MASK_LSB +: 8];
      end else begin
        plane_d = wr_ctrl_q[WR_SET_RESET_EN_LSB + p] ? {8{wr_ctrl_q[WR_SET_RESET_VAL_LSB + p]}} : rotated;
        plane_m = wr_ctrl_q[WR_BIT_MASK_LSB +: 8];
      end
      // clear mask bits keep the byte latched by the last read
      wr_word[p * 8 +: 8] = (plane_d & plane_m) | (latch_q[p * 8 +: 8] & ~plane_m);
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [1:0] req_plane;
  logic [7:0] cmp_bits;
  logic [7:0] sel_byte;

  // plane chosen for a mode 0 read
  always_comb begin
    if (rd_ctrl_q[RD_CHAIN4_BIT]) begin
      req_plane = RD_ADDR_IN[1:0];
    end else if (rd_ctrl_q[RD_RD_CHAIN2_BIT]) begin
      req_plane = {rd_ctrl_q[RD_PLANE_SEL_LSB + 1], RD_ADDR_IN[0]};
    end else begin
      req_plane = rd_ctrl_q[RD_PLANE_SEL_LSB +: 2];
    end
  end

  // colour compare: excluded planes always match
  always_comb begin
    cmp_bits = 8'hFF;
    for (int p = 0; p < PLANES; p++) begin
      if (rd_ctrl_q[RD_CMP_MASK_LSB + p]) begin
        cmp_bits = cmp_bits & ~(MEM_RDATA_IN[p * 8 +: 8] ^ {8{rd_ctrl_q[RD_CMP_VAL_LSB + p]}});
      end
    end
    sel_byte = MEM_RDATA_IN[rd_plane_q * 8 +: 8];
  end

  // ****************************************
  // memory request sequencing
  // ****************************************
  // next memory request and read return
  always_comb begin
    mem_d = '0;
    rd_plane_d = rd_plane_q;
    rd_valid_d = MEM_RDATA_VALID_IN;
    rd_data_d = rd_data_q;
    if (WR_REQ_IN) begin
      // a write takes the port when both arrive together
      mem_d.wr = 1'b1;
      mem_d.addr = map_addr(WR_ADDR_IN, base_q, rd_ctrl_q);
      mem_d.plane_en = wr_ctrl_q[WR_MAP_MASK_LSB +: 4] & chain_en;
      mem_d.data = wr_word;
    end else if (RD_REQ_IN) begin
      mem_d.rd = 1'b1;
      mem_d.addr = map_addr(RD_ADDR_IN, base_q, rd_ctrl_q);
      rd_plane_d = req_plane;
    end
    if (MEM_RDATA_VALID_IN) begin
      rd_data_d = rd_ctrl_q[RD_MODE_BIT] ? cmp_bits : sel_byte;
    end
  end

  // register stage of the memory side
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      mem_q <= '0;
      rd_plane_q <= 2'h0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      mem_q <= mem_d;
      rd_plane_q <= rd_plane_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign MEM_REQ_OUT = mem_q;
  assign RD_VALID_OUT = rd_valid_q;
  assign RD_DATA_OUT = rd_data_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  a_read_ctrl_reset: assert property (disable iff (1'b0) !RSTN_IN |=> rd_ctrl_q == READ_CTRL_RESET)
    else $error("read control not zero after reset");
  a_window_ack: assert property ((REG_REQ_IN.wr || REG_REQ_IN.rd) && hit |=> REG_ACK_OUT)
    else $error("access in window not acknowledged");
  a_base_readback: assert property (REG_REQ_IN.rd && REG_REQ_IN.addr == OFF_MEM_BASE
                                    |=> REG_RDATA_OUT[13:8] == $past(base_q) && REG_RDATA_OUT[7:0] == 8'h00)
    else $error("base read field wrong");
  a_latch_load: assert property (MEM_RDATA_VALID_IN && !(hit && REG_REQ_IN.wr && REG_REQ_IN.addr == OFF_LATCH)
                                 |=> latch_q == $past(MEM_RDATA_IN))
    else $error("latch not loaded by read");
  a_plane_en_mask: assert property (WR_REQ_IN |=> MEM_REQ_OUT.wr
                                    && (MEM_REQ_OUT.plane_en & ~$past(wr_ctrl_q[WR_MAP_MASK_LSB +: 4])) == 4'h0)
    else $error("plane enabled outside map mask");
  a_chain4_plane: assert property (WR_REQ_IN && rd_ctrl_q[RD_CHAIN4_BIT] |=> $onehot0(MEM_REQ_OUT.plane_en))
    else $error("chain 4 enabled more than one plane");
  a_force15_addr: assert property (RD_REQ_IN && !WR_REQ_IN && rd_ctrl_q[RD_FORCE15_BIT] && !rd_ctrl_q[RD_CHAIN4_BIT]
                                   && !rd_ctrl_q[RD_ODD_EVEN_BIT]
                                   |=> MEM_REQ_OUT.addr == ({$past(base_q), 14'h0000} + {5'h00, $past(RD_ADDR_IN[14:0])}))
    else $error("forced address bit 15 wrong");
  a_mode0_pass: assert property (WR_REQ_IN && wr_ctrl_q[WR_MODE3_BIT +: 1] == 1'b0 && !wr_ctrl_q[WR_MODE2_BIT]
                                 && wr_ctrl_q[WR_SET_RESET_EN_LSB +: 4] == 4'h0 && wr_ctrl_q[WR_ROTATE_LSB +: 3] == 3'h0
                                 && wr_ctrl_q[WR_BIT_MASK_LSB +: 8] == 8'hFF
                                 |=> MEM_REQ_OUT.data[7:0] == $past(WR_DATA_IN))
    else $error("mode 0 did not pass the cpu byte");
  a_read_return: assert property (MEM_RDATA_VALID_IN |=> RD_VALID_OUT ##1 (!RD_VALID_OUT || $past(MEM_RDATA_VALID_IN)))
    else $error("read return not presented");
  a_compare_none: assert property (MEM_RDATA_VALID_IN && rd_ctrl_q[RD_MODE_BIT] && rd_ctrl_q[RD_CMP_MASK_LSB +: 4] == 4'h0
                                   |=> RD_DATA_OUT == 8'hFF)
    else $error("empty compare set did not return all ones");

endmodule : vga_plane_path_control

`default_nettype wire

// ---- logic/vga_plane_path_pkg.sv ----
// package: register map, field layout and carrier types of the vga plane path control
package vga_plane_path_pkg;

  // ****************************************
  // register window
  // ****************************************
  localparam logic [15:0] REGION_START = 16'h8100; // first decoded offset
  localparam logic [15:0] REGION_END = 16'h8300; // first offset past the window
  localparam logic [15:0] OFF_WRITE_CTRL = 16'h8140; // vga_write_path_control
  localparam logic [15:0] OFF_READ_CTRL = 16'h8144; // vga_read_path_control
  localparam logic [15:0] OFF_MEM_BASE = 16'h8210; // vga_memory_base_offset
  localparam logic [15:0] OFF_LATCH = 16'h8214; // vga_display_latch

  // ****************************************
  // reset values and writable bits
  // ****************************************
  localparam logic [31:0] READ_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] WRITE_CTRL_RESET = 32'h0000_0000; // contents undefined, zero chosen
  localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
  localparam logic [5:0] BASE_RESET = 6'h00;
  localparam logic [31:0] WRITE_CTRL_MASK = 32'h0F1F_FFFF; // reserved bits stored as zero
  localparam logic [31:0] READ_CTRL_MASK = 32'h0003_FFFF;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BASE_WR_LSB = 0; // write-only base field
  localparam int BASE_RD_LSB = 8; // read-only base field
  localparam int BASE_W = 6;
  localparam int BASE_ADDR_LSB = 14; // longword address bit the base lands on
  localparam int WR_MAP_MASK_LSB = 24;
  localparam int WR_MODE3_BIT = 20;
  localparam int WR_MODE2_BIT = 19;
  localparam int WR_ROTATE_LSB = 16;
  localparam int WR_SET_RESET_EN_LSB = 12;
  localparam int WR_SET_RESET_VAL_LSB = 8;
  localparam int WR_BIT_MASK_LSB = 0;
  localparam int RD_PLANE_SEL_LSB = 16;
  localparam int RD_FORCE15_BIT = 15;
  localparam int RD_PACKED4_BIT = 14;
  localparam int RD_CHAIN4_BIT = 13;
  localparam int RD_PAGE_BIT = 12;
  localparam int RD_ODD_EVEN_BIT = 11;
  localparam int RD_WR_CHAIN2_BIT = 10;
  localparam int RD_RD_CHAIN2_BIT = 9;
  localparam int RD_MODE_BIT = 8;
  localparam int RD_CMP_MASK_LSB = 4;
  localparam int RD_CMP_VAL_LSB = 0;
  localparam int PLANES = 4;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic wr; // one-cycle register write strobe
    logic rd; // one-cycle register read strobe
    logic [15:0] addr; // offset from processor_register_base
    logic [31:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic wr; // one-cycle plane memory write
    logic rd; // one-cycle plane memory read
    logic [19:0] addr; // longword address in graphics memory
    logic [3:0] plane_en; // per-plane write enables
    logic [31:0] data; // plane 3 in the top byte
  } mem_req_type;

endpackage : vga_plane_path_pkg

// ---- verif/tb.sv ----
// file: self-checking bench for the vga plane path control block
`timescale 1ns/1ps
`default_nettype none
module tb
  import vga_plane_path_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  reg_req_type req = '0;
  logic hit, ack, rv, mv;
  logic wq = 1'b0;
  logic rq = 1'b0;
  logic [31:0] rdata, md;
  logic [15:0] wa = 16'h0000;
  logic [15:0] ra = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic [7:0] rd;
  mem_req_type mreq;
  // bench copies of the programmed state; reset contents are zero
  logic [31:0] wc = 32'h0000_0000;
  logic [31:0] rctl = 32'h0000_0000;
  logic [31:0] lat = 32'h0000_0000;
  logic [5:0] base = 6'h00;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  vga_plane_path_control dut_u (.REF_CLK_IN(clk), .RSTN_IN(rstn), .REG_REQ_IN(req), .REG_HIT_OUT(hit),
    .REG_ACK_OUT(ack), .REG_RDATA_OUT(rdata), .WR_REQ_IN(wq), .WR_ADDR_IN(wa), .WR_DATA_IN(wd),
    .RD_REQ_IN(rq), .RD_ADDR_IN(ra), .RD_VALID_OUT(rv), .RD_DATA_OUT(rd), .MEM_REQ_OUT(mreq),
    .MEM_RDATA_VALID_IN(mv), .MEM_RDATA_IN(md));
  vga_plane_memory_model mem_u (.clk_in(clk), .req_in(mreq), .valid_out(mv), .data_out(md));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ****************************************
  // expectations
  // ****************************************
  function automatic logic [31:0] word(input logic [19:0] a);
    return {a[11:0], a} ^ 32'h5A3C_96E1;
  endfunction : word

  // longword address after force, chain 4 and odd/even handling
  function automatic logic [19:0] lw(input logic [15:0] a);
    logic [15:0] v;
    v = a;
    if (rctl[15]) v[15] = 1'b0;
    if (rctl[13]) v = rctl[14] ? v >> 2 : v & 16'hFFFC;
    else if (rctl[11]) v[0] = rctl[12];
    return {base, 14'h0000} + {4'h0, v};
  endfunction : lw

  // plane enables: chain 4 picks one plane, write chain 2 odd or even pairs
  function automatic logic [3:0] pen(input logic [15:0] a);
    if (rctl[13]) return wc[27:24] & (4'h1 << a[1:0]);
    if (rctl[10]) return wc[27:24] & (a[0] ? 4'hA : 4'h5);
    return wc[27:24];
  endfunction : pen

  function automatic logic [7:0] rot(input logic [7:0] d);
    logic [15:0] t;
    t = {d, d} >> wc[18:16];
    return t[7:0];
  endfunction : rot

  // mode 3 outranks mode 2; masked-off bits keep the latch byte
  function automatic logic [31:0] wexp(input logic [7:0] d);
    logic [7:0] nb, m;
    logic [31:0] r;
    int p;
    for (p = 0; p < PLANES; p++) begin
      m = wc[7:0];
      if (wc[20]) begin
        nb = {8{wc[8+p]}};
        m = m & rot(d);
      end else if (wc[19]) nb = {8{d[p]}};
      else nb = wc[12+p] ? {8{wc[8+p]}} : rot(d);
      r[8*p +: 8] = (nb & m) | (lat[8*p +: 8] & ~m);
    end
    return r;
  endfunction : wexp

  function automatic logic [7:0] rexp(input logic [15:0] a);
    logic [7:0] r;
    logic [1:0] pl;
    int p;
    // chain 4 picks by the low two bits, read chain 2 by the high select bit and A0
    pl = rctl[13] ? a[1:0] : rctl[9] ? {rctl[17], a[0]} : rctl[17:16];
    if (!rctl[8]) return lat[8*pl +: 8];
    r = 8'hFF;
    for (p = 0; p < PLANES; p++) begin
      if (rctl[4+p]) r = r & ~(lat[8*p +: 8] ^ {8{rctl[p]}});
    end
    return r;
  endfunction : rexp

  // ****************************************
  // port drivers
  // ****************************************
  task automatic reg_op(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    logic in_win;
    in_win = (a >= REGION_START) && (a < REGION_END);
    @(posedge clk);
    #1;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    #1;
    chk(hit, in_win);
    @(posedge clk);
    #1;
    req = '0;
    chk(ack, in_win);
    q = rdata;
  endtask : reg_op

  task automatic put(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    reg_op(1'b1, a, d, q);
  endtask : put

  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wq = 1'b1;
    wa = a;
    wd = d;
    @(posedge clk);
    #1;
    wq = 1'b0;
    chk(mreq.wr, 1);
    chk(mreq.addr, lw(a));
    chk(mreq.plane_en, pen(a));
    chk(mreq.data, wexp(d));
  endtask : wr_byte

  task automatic rd_byte(input logic [15:0] a);
    @(posedge clk);
    #1;
    rq = 1'b1;
    ra = a;
    @(posedge clk);
    #1;
    rq = 1'b0;
    chk(mreq.rd, 1);
    chk(mreq.addr, lw(a));
    lat = word(lw(a));
    repeat (10) if (rv !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    chk(rv, 1);
    chk(rd, rexp(a));
  endtask : rd_byte

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] q, d;
    int i;
    logic [15:0] offs [4];
    offs = '{OFF_WRITE_CTRL, OFF_READ_CTRL, OFF_MEM_BASE, OFF_LATCH};
    void'($urandom(96));
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    // reset contents of every register
    foreach (offs[k]) begin
      reg_op(1'b0, offs[k], 32'h0, q);
      chk(q, 32'h0);
    end
    // outside the window nothing answers; unmapped inside reads zero
    put(16'h0144, 32'hFFFF_FFFF);
    reg_op(1'b0, 16'h8300, 32'h0, q);
    put(16'h82FC, 32'hFFFF_FFFF);
    reg_op(1'b0, 16'h82FC, 32'h0, q);
    chk(q, 32'h0);
    reg_op(1'b0, OFF_READ_CTRL, 32'h0, q);
    chk(q, 32'h0);
    // storage, reserved bits and the split base field
    foreach (offs[k]) begin
      for (i = 0; i < 4; i++) begin
        d = $urandom;
        put(offs[k], d);
        reg_op(1'b0, offs[k], 32'h0, q);
        chk(q, k == 0 ? d & WRITE_CTRL_MASK : k == 1 ? d & READ_CTRL_MASK : k == 2 ? {18'h0, d[5:0], 8'h00} : d);
      end
    end
    // write path over every mode, both chain kinds, packing, odd/even and bit 15 forcing
    for (i = 0; i < 24; i++) begin
      wc = $urandom & WRITE_CTRL_MASK;
      wc[20:19] = i[1:0];
      // corner: plain mode 0 with a full mask passes the cpu byte untouched
      if (i == 0) wc[18:0] = 19'h000FF;
      rctl = $urandom & 32'h0000_FC00;
      base = 6'($urandom);
      lat = $urandom;
      put(OFF_WRITE_CTRL, wc);
      put(OFF_READ_CTRL, rctl);
      put(OFF_MEM_BASE, {26'h0, base});
      put(OFF_LATCH, lat);
      wr_byte(16'($urandom), 8'($urandom));
    end
    // read path in both read modes; the loaded latch then feeds a write
    for (i = 0; i < 24; i++) begin
      rctl = $urandom & READ_CTRL_MASK;
      rctl[8] = i[0];
      // corners: empty compare set, and bit 15 forcing with chain 4 and odd/even off
      if (i == 1) rctl[7:4] = 4'h0;
      if (i == 2) rctl[15:11] = 5'h10;
      put(OFF_READ_CTRL, rctl);
      rd_byte(16'($urandom));
      reg_op(1'b0, OFF_LATCH, 32'h0, q);
      chk(q, lat);
      wr_byte(16'($urandom), 8'($urandom));
    end
    // a reset in mid-run clears the programmed read control again
    @(posedge clk);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    reg_op(1'b0, OFF_READ_CTRL, 32'h0, q);
    chk(q, READ_CTRL_RESET);
    end_of_test();
  end
endmodule : tb
`default_nettype wire

// ---- verif/vga_plane_memory_model.sv ----
// file: behavioural graphics memory answering plane reads of the block
`timescale 1ns/1ps
`default_nettype none
module vga_plane_memory_model
  import vga_plane_path_pkg::*;
(
  // clock
  input wire logic clk_in,
  // request from the block
  input wire mem_req_type req_in,
  // read answer
  output logic valid_out,
  output logic [31:0] data_out
);
  logic [19:0] addr_q; // address of the pending read
  int wait_q; // cycles left before the answer

  // contents are a fixed function of the address, so writes need no storage
  function automatic logic [31:0] word_at(input logic [19:0] a);
    return {a[11:0], a} ^ 32'h5A3C_96E1;
  endfunction : word_at

  // one process owns the pending read: answer first, then note a new request
  // answer promptly or slowly; data churns so stale bytes never pass
  initial begin
    valid_out = 1'b0;
    data_out = 32'h0000_0000;
    wait_q = 0;
    forever begin
      @(posedge clk_in);
      #1;
      valid_out = (wait_q == 1);
      data_out = valid_out ? word_at(addr_q) : ~data_out;
      if (wait_q != 0) wait_q--;
      if (req_in.rd) begin
        addr_q = req_in.addr;
        wait_q = 1 + $urandom_range(3);
      end
    end
  end
endmodule : vga_plane_memory_model
`default_nettype wire
